//--- hw/rpfs_filter.v
// Digital noise filter of the reset pin: counts consecutive low samples.
// Assumes the pin is already synchronous to pclk and sample_en marks a running sampling clock.
`timescale 1ns/1ps
`default_nettype none
module rpfs_filter #(
  parameter CW = 5
) (
  // Clock and reset
  input  wire          pclk,
  input  wire          presetn,
  // Sampling
  input  wire          sample_en,
  input  wire          pin_n,
  input  wire [CW-1:0] samples,
  // Result
  output reg           low_seen
);
  reg [CW-1:0] count_reg;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= {CW{1'b0}};
      low_seen  <= 1'b0;
    end else if (!sample_en || pin_n) begin
      count_reg <= {CW{1'b0}};
      low_seen  <= 1'b0;
    end else if (count_reg + 1'b1 >= samples) begin
      count_reg <= samples;
      low_seen  <= 1'b1;
    end else begin
      count_reg <= count_reg + 1'b1;
      low_seen  <= 1'b0;
    end
  end
endmodule // rpfs_filter
`default_nettype wire

//--- hw/rpfs_map.vh
// Register map, field positions, reset values and timing counts of the reset pin filter and sequencer.
// Assumes a 32-bit APB slave on pclk at 10 MHz; each register is one aligned word.
`ifndef RPFS_MAP_VH
`define RPFS_MAP_VH

`define RPFS_OFF_FILTER_CTRL   12'h000
`define RPFS_OFF_STATUS        12'h004
`define RPFS_OFF_SOURCE_FLAGS  12'h008
`define RPFS_OFF_POWER_CTRL    12'h00C
`define RPFS_OFF_STAB_SELECT   12'h010

`define RPFS_FILTER_CTRL_RESET 8'h00
`define RPFS_SOURCE_RESET      8'h00
`define RPFS_STAB_RESET        3'h4

`define RPFS_BIT_FILTER_SELECT 1
`define RPFS_BIT_SAMPLE_COUNT  0
`define RPFS_BIT_STOP_REQ      0
`define RPFS_BIT_CLOCK_SOURCE  1

`define RPFS_SAMPLES_LONG      5'h14
`define RPFS_SAMPLES_SHORT     5'h0A

// Stabilization is 2^(base + select) cycles of pclk
`define RPFS_STAB_BASE_LOG2    5'h0A
`define RPFS_CLK_DIV_LOG2      3
`define RPFS_CLK_PERIOD_NS     100

`endif

//--- hw/rpfs_sequencer.v
// Reset pin filter and reset sequencer with an APB register slave.
// Assumes reset_pin_n and all control inputs are synchronous to pclk; presetn is power-on reset only.
`timescale 1ns/1ps
`default_nettype none
`include "rpfs_map.vh"
module rpfs_sequencer #(
  parameter STAB_MAX_LOG2 = 17
) (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Reset pin and analog path
  input  wire        reset_pin_n,
  input  wire        analog_reset_n,
  // Other reset sources setting source flags
  input  wire [3:0]  source_set,
  // Clock and reset outputs
  output reg         main_osc_en,
  output reg         sys_clk_en,
  output reg         periph_clk_en,
  output reg         clk_div8,
  output reg         cpu_run,
  output reg         periph_run,
  output reg         unit_reset_n,
  // Reset output port line and other ports
  output reg         reset_output_port_line,
  output reg         reset_output_port_oe,
  output reg         ports_oe_allowed,
  // Internal RAM guard
  input  wire        ram_write_req,
  output reg         ram_write_en
);
  localparam ST_RESET = 2'h0;
  localparam ST_STAB  = 2'h1;
  localparam ST_RUN   = 2'h2;

  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [7:0]  reset_filter_control_reg;
  reg         lock_reg;
  reg  [7:0]  reset_source_flags_reg;
  reg         stop_mode_reg;
  reg         clock_source_bit_reg;
  reg  [2:0]  stabilization_time_select_reg;
  reg         stop_stab_reg;
  reg  [23:0] stab_cnt_reg;
  reg  [23:0] wake_cnt_reg;
  wire        digital_low;
  wire        filter_select_bit;
  wire        sample_count_bit;
  wire        sample_clock_running;
  wire        use_digital;
  wire        pin_reset;
  wire        apb_write;
  wire        apb_read;
  wire [23:0] stab_target;
  wire [4:0]  sample_target;

  ////////////////////////////////////////////////////////////////////////
  // Filter selection
  assign filter_select_bit    = reset_filter_control_reg[`RPFS_BIT_FILTER_SELECT];
  assign sample_count_bit     = reset_filter_control_reg[`RPFS_BIT_SAMPLE_COUNT];
  // Stop mode, wakeup stabilization and subclock all leave no sampling clock
  assign sample_clock_running = main_osc_en && !stop_mode_reg && !stop_stab_reg
                                && !clock_source_bit_reg;
  assign use_digital          = filter_select_bit && sample_clock_running;
  assign sample_target        = sample_count_bit ? `RPFS_SAMPLES_SHORT : `RPFS_SAMPLES_LONG;

  rpfs_filter #(
    .CW        (5)
  ) u_filter (
    .pclk      (pclk),
    .presetn   (presetn),
    .sample_en (use_digital),
    .pin_n     (reset_pin_n),
    .samples   (sample_target),
    .low_seen  (digital_low)
  );

  // Analog path always acts; digital path adds a sampled low when enabled
  assign pin_reset = !analog_reset_n || (use_digital ? digital_low : !reset_pin_n);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  assign stab_target = 24'h1 << (`RPFS_STAB_BASE_LOG2 + {2'b00, stabilization_time_select_reg});

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RESET: begin
        if (!pin_reset) begin
          state_next = ST_STAB;
        end
      end
      ST_STAB: begin
        if (pin_reset) begin
          state_next = ST_RESET;
        end else if (stab_cnt_reg >= stab_target - 24'h1) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (pin_reset) begin
          state_next = ST_RESET;
        end
      end
      default: begin
        state_next = ST_RESET;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_RESET;
      stab_cnt_reg <= 24'h0;
    end else begin
      state_reg    <= state_next;
      stab_cnt_reg <= (state_reg == ST_STAB) ? stab_cnt_reg + 24'h1 : 24'h0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_en            <= 1'b0;
      sys_clk_en             <= 1'b0;
      periph_clk_en          <= 1'b0;
      clk_div8               <= 1'b1;
      cpu_run                <= 1'b0;
      periph_run             <= 1'b0;
      unit_reset_n           <= 1'b0;
      reset_output_port_line <= 1'b0;
      reset_output_port_oe   <= 1'b1;
      ports_oe_allowed       <= 1'b0;
      ram_write_en           <= 1'b0;
    end else begin
      main_osc_en            <= (state_next != ST_RESET);
      sys_clk_en             <= (state_next == ST_RUN);
      periph_clk_en          <= (state_next == ST_RUN);
      clk_div8               <= (state_next != ST_RUN) ? 1'b1 : clk_div8;
      cpu_run                <= (state_next == ST_RUN);
      periph_run             <= (state_next == ST_RUN);
      unit_reset_n           <= (state_next != ST_RESET);
      reset_output_port_line <= 1'b0;
      reset_output_port_oe   <= (state_next == ST_RESET);
      ports_oe_allowed       <= (state_next != ST_RESET);
      ram_write_en           <= ram_write_req && !pin_reset && (state_reg == ST_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave
  assign apb_write = psel && penable && pwrite;
  assign apb_read  = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_filter_control_reg      <= `RPFS_FILTER_CTRL_RESET;
      lock_reg                      <= 1'b0;
      reset_source_flags_reg        <= `RPFS_SOURCE_RESET;
      stop_mode_reg                 <= 1'b0;
      clock_source_bit_reg          <= 1'b0;
      stabilization_time_select_reg <= `RPFS_STAB_RESET;
      stop_stab_reg                 <= 1'b0;
      wake_cnt_reg                  <= 24'h0;
      pready                        <= 1'b0;
      pslverr                       <= 1'b0;
      prdata                        <= 32'h0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (pin_reset) begin
        reset_filter_control_reg <= `RPFS_FILTER_CTRL_RESET;
        lock_reg                 <= 1'b0;
        reset_source_flags_reg   <= `RPFS_SOURCE_RESET;
        stop_mode_reg            <= 1'b0;
        clock_source_bit_reg     <= 1'b0;
        stop_stab_reg            <= 1'b0;
        wake_cnt_reg             <= 24'h0;
      end else begin
        // Stop wakeup keeps analog-only until stabilization has run out
        if (stop_stab_reg) begin
          if (wake_cnt_reg >= stab_target - 24'h1) begin
            stop_stab_reg <= 1'b0;
            wake_cnt_reg  <= 24'h0;
          end else begin
            wake_cnt_reg  <= wake_cnt_reg + 24'h1;
          end
        end
        if (apb_write && paddr == `RPFS_OFF_FILTER_CTRL && !lock_reg) begin
          reset_filter_control_reg <= pwdata[7:0];
          lock_reg                 <= 1'b1;
        end
        if (apb_write && paddr == `RPFS_OFF_POWER_CTRL) begin
          if (stop_mode_reg && !pwdata[`RPFS_BIT_STOP_REQ]) begin
            stop_stab_reg <= 1'b1;
            wake_cnt_reg  <= 24'h0;
          end
          stop_mode_reg        <= pwdata[`RPFS_BIT_STOP_REQ];
          clock_source_bit_reg <= pwdata[`RPFS_BIT_CLOCK_SOURCE];
        end
        if (apb_write && paddr == `RPFS_OFF_STAB_SELECT) begin
          stabilization_time_select_reg <= pwdata[2:0];
        end
        // Only zeros write; a new source event wins over the clear
        reset_source_flags_reg <= {4'h0, source_set |
          ((apb_write && paddr == `RPFS_OFF_SOURCE_FLAGS) ?
           (reset_source_flags_reg[3:0] & pwdata[3:0]) : reset_source_flags_reg[3:0])};
      end
      if (apb_read) begin
        case (paddr)
          `RPFS_OFF_FILTER_CTRL:  prdata <= {24'h0, reset_filter_control_reg};
          `RPFS_OFF_STATUS:       prdata <= {26'h0, lock_reg, use_digital, cpu_run, state_reg, digital_low};
          `RPFS_OFF_SOURCE_FLAGS: prdata <= {24'h0, reset_source_flags_reg};
          `RPFS_OFF_POWER_CTRL:   prdata <= {29'h0, stop_stab_reg, clock_source_bit_reg, stop_mode_reg};
          `RPFS_OFF_STAB_SELECT:  prdata <= {29'h0, stabilization_time_select_reg};
          default: begin
            prdata <= 32'h0;
          end
        endcase
      end
      if (psel && !penable && !(paddr == `RPFS_OFF_FILTER_CTRL || paddr == `RPFS_OFF_STATUS ||
          paddr == `RPFS_OFF_SOURCE_FLAGS || paddr == `RPFS_OFF_POWER_CTRL ||
          paddr == `RPFS_OFF_STAB_SELECT)) begin
        pslverr <= 1'b1;
      end
    end
  end
endmodule // rpfs_sequencer
`default_nettype wire

//--- verification/rpfs_pin_source.sv
// Board-level reset source that drives the reset pin and its analog path.
// Assumes pclk stands in for the main oscillator sampling clock.
`timescale 1ns/1ps
`default_nettype none
module rpfs_pin_source (
  // Clock
  input  wire logic pclk,
  // Pin
  output var logic  reset_pin_n,
  output var logic  analog_reset_n
);
  initial begin
    reset_pin_n = 1'b1;
    analog_reset_n = 1'b1;
  end
  ////////////////////////////////////////
  // Low for n sampling edges; the analog path follows only when asked, as a short glitch may not pass it
  task automatic pulse(input int n, input logic ana);
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    analog_reset_n <= ~ana;
    repeat (n) @(posedge pclk);
    reset_pin_n <= 1'b1;
    analog_reset_n <= 1'b1;
  endtask
endmodule // rpfs_pin_source
`default_nettype wire

//--- verification/rpfs_props.sv
// Port checker for the reset pin filter and sequencer.
// Assumes it is bound to every rpfs_sequencer instance.
`timescale 1ns/1ps
`default_nettype none
module rpfs_props (
  // Clock, reset, APB
  input wire logic pclk, presetn, psel, penable, pready,
  // Pin and clock control
  input wire logic analog_reset_n, main_osc_en, sys_clk_en, periph_clk_en, clk_div8,
  input wire logic cpu_run, periph_run, unit_reset_n,
  // Ports and RAM guard
  input wire logic reset_output_port_line, reset_output_port_oe, ports_oe_allowed,
  input wire logic ram_write_req, ram_write_en
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence in_reset;
    !unit_reset_n;
  endsequence
  ////////////////////////////////////////
  // Saturates so a long stabilization cannot wrap to a small value
  logic [15:0] stab_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || !unit_reset_n)
      stab_cnt <= 16'h0000;
    else if (!cpu_run && stab_cnt != 16'hFFFF)
      stab_cnt <= stab_cnt + 16'h0001;
  end
  ////////////////////////////////////////
  osc_stop_a: assert property (in_reset |-> !main_osc_en) else $error("oscillator runs in reset");
  clk_stop_a: assert property (in_reset |-> !sys_clk_en && !periph_clk_en) else $error("clock in reset");
  run_hold_a: assert property (in_reset |-> !cpu_run && !periph_run) else $error("run in reset");
  port_state_a: assert property (in_reset |-> reset_output_port_oe && !reset_output_port_line && !ports_oe_allowed)
    else $error("port state in reset");
  stab_wait_a: assert property ($rose(cpu_run) |-> stab_cnt >= 16'h03FF) else $error("cpu early");
  div_init_a: assert property ($rose(sys_clk_en) |-> clk_div8) else $error("clock not divided");
  ram_guard_a: assert property (ram_write_en |-> $past(ram_write_req) && unit_reset_n)
    else $error("ram write in reset");
  analog_rst_a: assert property (!analog_reset_n |-> ##[1:3] !unit_reset_n) else $error("no reset");
  apb_ready_a: assert property (apb_setup |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
endmodule // rpfs_props
bind rpfs_sequencer rpfs_props i_props (.pclk, .presetn, .psel, .penable, .pready, .analog_reset_n, .main_osc_en,
  .sys_clk_en, .periph_clk_en, .clk_div8, .cpu_run, .periph_run, .unit_reset_n, .reset_output_port_line,
  .reset_output_port_oe, .ports_oe_allowed, .ram_write_req, .ram_write_en);
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the reset pin filter and sequencer.
// Assumes pclk also serves as the main oscillator sampling clock.
`timescale 1ns/1ps
`default_nettype none
`include "rpfs_map.vh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, reset_pin_n, analog_reset_n;
  logic        main_osc_en, sys_clk_en, periph_clk_en, clk_div8, cpu_run, periph_run, unit_reset_n;
  logic        reset_output_port_line, reset_output_port_oe, ports_oe_allowed, ram_write_req, ram_write_en;
  logic        seen_rst, err;
  logic [3:0]  source_set;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          n_errors, num_checks, cycles;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
  rpfs_sequencer i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .reset_pin_n, .analog_reset_n, .source_set, .main_osc_en, .sys_clk_en, .periph_clk_en, .clk_div8, .cpu_run,
    .periph_run, .unit_reset_n, .reset_output_port_line, .reset_output_port_oe, .ports_oe_allowed,
    .ram_write_req, .ram_write_en);
  rpfs_pin_source i_pin (.pclk, .reset_pin_n, .analog_reset_n);
  ////////////////////////////////////////
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (unit_reset_n === 1'b0) seen_rst <= 1'b1;
    if (cycles == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  ////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 40);
    if (n == 40) begin n_errors++; $display("[ERR] %0t no answer", $time); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset may already be over when the check runs 4 cycles after the pin rises, hence the sticky flag
  task automatic glitch(input int n, input logic ana, input logic exp);
    @(posedge pclk) seen_rst <= 1'b0;
    i_pin.pulse(n, ana);
    repeat (4) @(posedge pclk);
    `CHK(seen_rst, exp)
  endtask
  task automatic recover();
    int n;
    n = 0;
    while (cpu_run !== 1'b1 && n < 20000) begin @(posedge pclk); n++; end
    `CHK(n >= 1010, 1'b1)
    `CHK({sys_clk_en, periph_clk_en, periph_run, clk_div8}, 4'hF)
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    recover();
    apb(0, `RPFS_OFF_FILTER_CTRL, 32'h0);
    `CHK(rd, 32'h0)
    apb(0, `RPFS_OFF_STAB_SELECT, 32'h0);
    `CHK(rd[2:0], `RPFS_STAB_RESET)
    apb(0, 12'hFFC, 32'h0);
    `CHK(err, 1'b1)
    apb(1, `RPFS_OFF_STAB_SELECT, 32'h0);
    apb(1, `RPFS_OFF_FILTER_CTRL, 32'h3);
    apb(1, `RPFS_OFF_FILTER_CTRL, 32'h0);
    apb(0, `RPFS_OFF_FILTER_CTRL, 32'h0);
    `CHK(rd, 32'h3)
  endtask
  task automatic t_digital();
    @(posedge pclk) source_set <= 4'hF;
    @(posedge pclk) source_set <= 4'h0;
    apb(0, `RPFS_OFF_SOURCE_FLAGS, 32'h0);
    `CHK(rd, 32'hF)
    glitch(9, 0, 0);
    glitch(10, 0, 1);
    recover();
    apb(0, `RPFS_OFF_SOURCE_FLAGS, 32'h0);
    `CHK(rd, 32'h0)
    apb(0, `RPFS_OFF_FILTER_CTRL, 32'h0);
    `CHK(rd, 32'h0)
  endtask
  task automatic t_forced();
    apb(1, `RPFS_OFF_FILTER_CTRL, 32'h2);
    glitch(19, 0, 0);
    glitch(3, 0, 0);
    apb(1, `RPFS_OFF_POWER_CTRL, 32'h2);
    glitch(3, 0, 1);
    recover();
    glitch(2, 1, 1);
    recover();
    // Stop entry forces analog-only even with the digital filter selected
    apb(1, `RPFS_OFF_FILTER_CTRL, 32'h2);
    apb(1, `RPFS_OFF_POWER_CTRL, 32'h1);
    glitch(3, 0, 1);
    recover();
    // Wakeup from stop keeps analog-only while the stabilization runs
    apb(1, `RPFS_OFF_FILTER_CTRL, 32'h2);
    apb(1, `RPFS_OFF_POWER_CTRL, 32'h1);
    apb(1, `RPFS_OFF_POWER_CTRL, 32'h0);
    apb(0, `RPFS_OFF_POWER_CTRL, 32'h0);
    `CHK(rd[2:0], 3'h4)
    glitch(3, 0, 1);
    recover();
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, num_checks);
    if (n_errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    source_set = 4'h0;
    ram_write_req = 1'b1;
    seen_rst = 1'b0;
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_digital();
    t_forced();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
